// ---- core/ajr_applicant.sv ----
// End-station applicant: sends two joins per attribute on request
//
// Functional notes
// [R1] A join request in VO moves the attribute to VP to await an opportunity.
// [R2] An opportunity in VP sends one JoinEmpty and moves to AA.
// [R3] The next opportunity in AA sends a second JoinEmpty and moves to QA.
// [R4] A peer registrar in MT moves to IN on a JoinEmpty; its applicant stays VO.
// [R5] A peer registrar already IN ignores a further JoinEmpty.
// [R6] An unseen JoinEmpty changes nothing at the peer and nothing is acknowledged.
// [R7] A peer that missed the first JoinEmpty registers on the second.
// [R8] This end station keeps applicant state only and has no registrar.
// [R9] Losing the second JoinEmpty still ends with QA here and IN at the peer.
// [R10] JoinEmpty goes out when no other joiner is seen, JoinIn otherwise.
// [R11] The peer registrar never transmits and only records registration.
// [R12] At most one message per opportunity, with the state change in that cycle.
`timescale 1ns/1ps
`default_nettype none
module ajr_applicant #(
  parameter int NUM_ATTR = ajr_pkg::NUM_ATTR_DEF,
  parameter int AW = (NUM_ATTR > 1) ? $clog2(NUM_ATTR) : 1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic req_join_i,
  input wire logic [AW-1:0] req_attr_i,
  input wire logic tx_opp_i,
  input wire logic [NUM_ATTR-1:0] other_join_seen_i,
  output logic msg_valid_o,
  output logic msg_join_in_o,
  output logic [AW-1:0] msg_attr_o,
  output logic [NUM_ATTR-1:0][3:0] attr_state_o
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    ajr_pkg::ajr_app_state_t [NUM_ATTR-1:0] st;
    logic msg_valid;
    logic msg_join_in;
    logic [AW-1:0] msg_attr;
  } ajr_regs_t;

  ajr_regs_t s;
  ajr_regs_t next_s;

  ajr_pick_if #(.N(NUM_ATTR), .AW(AW)) pk ();

  ajr_pick #(.N(NUM_ATTR), .AW(AW)) u_pick (
    .pk(pk.arb)
  );

  // ********************************************************************
  // Pending transmissions
  // ********************************************************************
  // Only attributes still owing a join compete for the opportunity
  always_comb begin
    for (int i = 0; i < NUM_ATTR; i++) begin
      pk.pend[i] = (s.st[i] == ajr_pkg::APP_VP) || (s.st[i] == ajr_pkg::APP_AA);
    end
  end

  // ********************************************************************
  // Next state
  // ********************************************************************
  // Request and grant never hit the same attribute: one needs VO, the other VP/AA
  always_comb begin
    next_s = s;
    next_s.msg_valid = 1'b0;
    if (req_join_i && s.st[req_attr_i] == ajr_pkg::APP_VO) begin
      next_s.st[req_attr_i] = ajr_pkg::APP_VP;  // R1
    end
    // One grant per opportunity, so one message at most
    if (tx_opp_i && pk.gnt_valid) begin  // R12
      next_s.msg_valid = 1'b1;
      next_s.msg_attr = pk.gnt_idx;
      // Flavour follows what was seen locally; no registrar kept here
      next_s.msg_join_in = other_join_seen_i[pk.gnt_idx] ? ajr_pkg::MSG_JOIN_IN
                                                         : ajr_pkg::MSG_JOIN_EMPTY;  // R10 R8
      case (s.st[pk.gnt_idx])
        ajr_pkg::APP_VP: begin
          next_s.st[pk.gnt_idx] = ajr_pkg::APP_AA;  // R2
        end
        ajr_pkg::APP_AA: begin
          next_s.st[pk.gnt_idx] = ajr_pkg::APP_QA;  // R3
        end
        default: begin
          next_s.st[pk.gnt_idx] = s.st[pk.gnt_idx];
        end
      endcase
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  // Message and state update on the same edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
      for (int i = 0; i < NUM_ATTR; i++) begin
        s.st[i] <= ajr_pkg::APP_RESET;
      end
    end else begin
      s <= next_s;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign msg_valid_o = s.msg_valid;
  assign msg_join_in_o = s.msg_join_in;
  assign msg_attr_o = s.msg_attr;
  assign attr_state_o = s.st;

  // ********************************************************************
  // Checks
  // ********************************************************************
  logic [NUM_ATTR-1:0] vo_mask;
  logic [NUM_ATTR-1:0] req_mask;
  logic seen_of_gnt;
  logic [NUM_ATTR-1:0] vp_mask;
  logic [NUM_ATTR-1:0] aa_mask;
  logic [NUM_ATTR-1:0] qa_mask;
  logic [NUM_ATTR-1:0] gnt_mask;

  // One bit per attribute that sits in the given state
  function automatic logic [NUM_ATTR-1:0] state_mask(
    input ajr_pkg::ajr_app_state_t [NUM_ATTR-1:0] st,
    input ajr_pkg::ajr_app_state_t code
  );
    logic [NUM_ATTR-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_ATTR; i++) begin
      m[i] = (st[i] == code);
    end
    return m;
  endfunction : state_mask

  // Helper views read only by the checks below
  always_comb begin
    for (int i = 0; i < NUM_ATTR; i++) begin
      vo_mask[i] = (s.st[i] == ajr_pkg::APP_VO);
      req_mask[i] = req_join_i && (req_attr_i == AW'(i));
      gnt_mask[i] = tx_opp_i && pk.gnt_valid && (pk.gnt_idx == AW'(i));
    end
    seen_of_gnt = other_join_seen_i[pk.gnt_idx];
    vp_mask = state_mask(s.st, ajr_pkg::APP_VP);
    aa_mask = state_mask(s.st, ajr_pkg::APP_AA);
    qa_mask = state_mask(s.st, ajr_pkg::APP_QA);
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_join_to_vp: assert property ( // R1
    req_join_i && s.st[req_attr_i] == ajr_pkg::APP_VO
    |=> s.st[$past(req_attr_i)] == ajr_pkg::APP_VP)
    else $error("Join request in VO did not reach VP");

  a_vp_first_join: assert property ( // R2
    tx_opp_i && pk.gnt_valid && s.st[pk.gnt_idx] == ajr_pkg::APP_VP
    |=> msg_valid_o && msg_attr_o == $past(pk.gnt_idx)
        && s.st[msg_attr_o] == ajr_pkg::APP_AA)
    else $error("VP opportunity did not send first join and enter AA");

  a_aa_second_join: assert property ( // R3
    tx_opp_i && pk.gnt_valid && s.st[pk.gnt_idx] == ajr_pkg::APP_AA
    |=> msg_valid_o && msg_attr_o == $past(pk.gnt_idx)
        && s.st[msg_attr_o] == ajr_pkg::APP_QA)
    else $error("AA opportunity did not send second join and enter QA");

  a_vo_own_only: assert property ( // R8
    1'b1 |=> ((($past(vo_mask) & ~vo_mask) & ~$past(req_mask)) == '0))
    else $error("Attribute left VO without its own join request");

  a_join_flavour: assert property ( // R10
    tx_opp_i && pk.gnt_valid |=> msg_join_in_o == $past(seen_of_gnt))
    else $error("Join flavour does not match other-joiner view");

  a_one_per_opp: assert property ( // R12
    msg_valid_o |-> $past(tx_opp_i) && $past(pk.gnt_valid))
    else $error("Message emitted without a transmission opportunity");

  // ********************************************************************
  // Progress checks
  // ********************************************************************
  // A pending first join only moves on when its own opportunity is granted
  a_vp_holds: assert property ( // R1
    1'b1 |=> (($past(vp_mask) & ~vp_mask & ~$past(gnt_mask)) == '0))
    else $error("Attribute left VP without a granted opportunity");

  // The second join also waits for a grant of its own
  a_aa_holds: assert property ( // R3
    1'b1 |=> (($past(aa_mask) & ~aa_mask & ~$past(gnt_mask)) == '0))
    else $error("Attribute left AA without a granted opportunity");

  // QA is terminal here, so no third join can ever go out
  a_qa_final: assert property ( // R3
    1'b1 |=> (($past(qa_mask) & ~qa_mask) == '0))
    else $error("Attribute left QA");

  // A shared opportunity may advance one attribute only
  a_one_advance: assert property ( // R12
    1'b1 |=> $onehot0(($past(vp_mask) & aa_mask)
                      | ($past(aa_mask) & qa_mask)))
    else $error("More than one attribute advanced in one cycle");

  // The emitted attribute already shows its new state alongside the message
  a_msg_with_step: assert property ( // R12
    msg_valid_o |-> (s.st[msg_attr_o] == ajr_pkg::APP_AA)
                    || (s.st[msg_attr_o] == ajr_pkg::APP_QA))
    else $error("Message shown without the matching state step");

  // Message fields hold between messages so the far side can read them late
  a_fields_hold: assert property ( // R12
    !msg_valid_o |-> $stable(msg_attr_o) && $stable(msg_join_in_o))
    else $error("Message fields changed without a message");

endmodule : ajr_applicant
`default_nettype wire

// ---- core/ajr_pick.sv ----
// Fixed-priority picker: lowest pending attribute wins the opportunity
`timescale 1ns/1ps
`default_nettype none
module ajr_pick #(
  parameter int N = 4,
  parameter int AW = 2
) (
  ajr_pick_if.arb pk
);

  // Lowest index first; a starved high index only waits a few opportunities
  always_comb begin
    pk.gnt_valid = 1'b0;
    pk.gnt_idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pk.pend[i]) begin
        pk.gnt_valid = 1'b1;
        pk.gnt_idx = AW'(i);
      end
    end
  end

endmodule : ajr_pick
`default_nettype wire

// ---- core/ajr_pick_if.sv ----
// Pending-transmission request and grant between applicant and picker
`timescale 1ns/1ps
`default_nettype none
interface ajr_pick_if #(
  parameter int N = 4,
  parameter int AW = 2
);
  logic [N-1:0] pend;
  logic gnt_valid;
  logic [AW-1:0] gnt_idx;

  modport req (output pend, input gnt_valid, input gnt_idx);
  modport arb (input pend, output gnt_valid, output gnt_idx);
endinterface : ajr_pick_if
`default_nettype wire

// ---- core/ajr_pkg.sv ----
// Shared constants and types for the attribute join applicant
package ajr_pkg;

  // ********************************************************************
  // Sizing
  // ********************************************************************
  localparam int NUM_ATTR_DEF = 4;  // Attributes tracked by default

  // ********************************************************************
  // Applicant states, one-hot
  // ********************************************************************
  typedef enum logic [3:0] {
    APP_VO = 4'h1,  // Very anxious observer
    APP_VP = 4'h2,  // Very anxious passive, first join pending
    APP_AA = 4'h4,  // Anxious active, second join pending
    APP_QA = 4'h8   // Quiet active, both joins sent
  } ajr_app_state_t;

  localparam ajr_app_state_t APP_RESET = APP_VO;

  // ********************************************************************
  // Message flavour on msg_join_in_o
  // ********************************************************************
  localparam logic MSG_JOIN_EMPTY = 1'b0;
  localparam logic MSG_JOIN_IN = 1'b1;

endpackage : ajr_pkg

// ---- verification/ajr_applicant_tb.sv ----
// Self-checking bench for the join applicant against a reference model
`timescale 1ns/1ps
`default_nettype none
module ajr_applicant_tb;
  localparam int N = 4;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic req_join_i = 1'b0;
  logic [1:0] req_attr_i = 2'h0;
  logic tx_opp_i = 1'b0;
  logic [N-1:0] other_join_seen_i = 4'h0;
  logic drop = 1'b0;
  logic msg_valid_o;
  logic msg_join_in_o;
  logic [1:0] msg_attr_o;
  logic [N-1:0][3:0] attr_state_o;
  logic [N-1:0] reg_in;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int st [N];
  int ea;
  int w;
  bit ev;
  bit ej;
  bit [N-1:0] er;

  // 10 MHz clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  ajr_applicant i_ajr_applicant (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .req_join_i(req_join_i), .req_attr_i(req_attr_i), .tx_opp_i(tx_opp_i),
    .other_join_seen_i(other_join_seen_i), .msg_valid_o(msg_valid_o),
    .msg_join_in_o(msg_join_in_o), .msg_attr_o(msg_attr_o), .attr_state_o(attr_state_o));

  ajr_reg_model i_ajr_reg_model (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .msg_valid_i(msg_valid_o), .msg_attr_i(msg_attr_o), .drop_i(drop), .reg_in_o(reg_in));

  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    n_compared++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask : check

  task automatic finish_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // Hang guard, well above the roughly 400 cycles the run needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // Rounds of reset then random traffic; QA is terminal, so reset reopens joins
  initial begin
    void'($urandom(32'hea0a));
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      req_join_i <= 1'b0;
      tx_opp_i <= 1'b0;
      repeat ((k == 0) ? 20 : 2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      foreach (st[i]) st[i] = 0;
      ev = 0;
      ej = 0;
      ea = 0;
      er = '0;
      repeat (60) begin
        @(negedge clk_i);
        check(msg_valid_o, ev);
        check(msg_attr_o, 8'(ea));
        check(msg_join_in_o, ej);
        for (int i = 0; i < N; i++) check(attr_state_o[i], 8'(4'h1 << st[i]));
        check(reg_in, er);
        // Reference step for the inputs the next edge will sample
        w = -1;
        for (int i = N - 1; i >= 0; i--) if (st[i] == 1 || st[i] == 2) w = i;
        if (ev && !drop) er[ea] = 1'b1;
        if (req_join_i && st[req_attr_i] == 0) st[req_attr_i] = 1;
        ev = tx_opp_i && (w >= 0);
        if (ev) begin
          ea = w;
          ej = other_join_seen_i[w];
          st[w]++;
        end
        @(posedge clk_i);
        req_join_i <= ($urandom_range(2) == 0);
        req_attr_i <= 2'($urandom_range(3));
        tx_opp_i <= 1'($urandom_range(1));
        other_join_seen_i <= 4'($urandom_range(15));
        drop <= ($urandom_range(3) == 0);
      end
    end
    finish_test();
  end
endmodule : ajr_applicant_tb
`default_nettype wire

// ---- verification/ajr_reg_model.sv ----
// Bridge-side registrar model that records joins heard on the segment
`timescale 1ns/1ps
`default_nettype none
module ajr_reg_model #(
  parameter int N = 4,
  parameter int AW = 2
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic msg_valid_i,
  input wire logic [AW-1:0] msg_attr_i,
  input wire logic drop_i,
  output logic [N-1:0] reg_in_o
);
  // Passive by design: no reply path exists, so a lost join is never repaired here
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_in_o <= '0;
    end else if (msg_valid_i && !drop_i) begin
      reg_in_o[msg_attr_i] <= 1'b1;
    end
  end
endmodule : ajr_reg_model
`default_nettype wire
